// >>> src/pshp_params.svh
// constants of the slot hot-plug control and status block
// assumes 16-bit configuration accesses at byte offsets, two byte lanes
//
// Summary of operation
// - power indicator field reads present state
// - power indicator write updates and sends message
// - attention indicator field reads present state
// - attention indicator write updates and sends message
// - master enable gates every hot-plug interrupt
// - command completion interrupts when enabled
// - presence change interrupts or wakes when enabled
// - button press interrupts or wakes when enabled
// - presence state bit from strap, then pin
// - command completed set on finished command
// - presence changed set on either edge
// - button pressed set on detected press
// - status event bits are write-one-to-clear
`ifndef PSHP_PARAMS_SVH
`define PSHP_PARAMS_SVH

// register offsets
`define PSHP_SLOT_CONTROL_OFF 8'hb8
`define PSHP_SLOT_STATUS_OFF  8'hba

// reset values
`define PSHP_SLOT_CONTROL_RST 16'h01c0
`define PSHP_SLOT_STATUS_RST  16'h0000

// slot control field positions
`define PSHP_CTL_PWR_HI  9
`define PSHP_CTL_PWR_LO  8
`define PSHP_CTL_ATTN_HI 7
`define PSHP_CTL_ATTN_LO 6
`define PSHP_CTL_HPIE    5
`define PSHP_CTL_CCIE    4
`define PSHP_CTL_PDCE    3
`define PSHP_CTL_ABPE    0

// slot status field positions
`define PSHP_STS_PDS 6
`define PSHP_STS_CC  4
`define PSHP_STS_PDC 3
`define PSHP_STS_ABP 0

// indicator encodings
`define PSHP_IND_RSVD  2'h0
`define PSHP_IND_ON    2'h1
`define PSHP_IND_BLINK 2'h2
`define PSHP_IND_OFF   2'h3

// message kinds
`define PSHP_MSG_POWER 1'h0
`define PSHP_MSG_ATTN  1'h1

// synchroniser depth for pins
`define PSHP_SYNC_STAGES 2

`endif

// >>> src/pshp_pkg.sv
// types of the slot hot-plug control and status block
// assumes the constants header is included by the design file
package pshp_pkg;

	// indicator message sender states, one-hot
	typedef enum logic [1:0] {
		PSHP_MSG_IDLE = 2'b01,
		PSHP_MSG_BUSY = 2'b10
	} pshp_msg_state_e;

	// two-bit indicator state
	typedef logic [1:0] pshp_ind_t;

	// sixteen-bit register word
	typedef logic [15:0] pshp_word_t;

endpackage

// >>> src/pshp_slot_ctl.sv
// slot control and slot status registers of a hot-plug root port
// assumes a simple configuration port on clk_i, a message path with
// valid/ready, and raw slot pins that need synchronising
`timescale 1ns/100ps
`include "pshp_params.svh"

module pshp_slot_ctl (
	input  wire logic               clk_i,         // 200 MHz port clock
	input  wire logic               sys_rst_i,     // async reset, active high
	input  wire logic [7:0]         cfg_addr_i,    // byte offset of access
	input  wire logic               cfg_wr_i,      // write strobe
	input  wire logic               cfg_rd_i,      // read strobe
	input  wire logic [1:0]         cfg_be_i,      // byte enables
	input  wire logic [15:0]        cfg_wdata_i,   // write data
	output logic      [15:0]        cfg_rdata_o,   // read data
	output logic                    cfg_rvalid_o,  // read data valid pulse
	input  wire logic               cmd_done_i,    // controller finished command
	input  wire logic               presence_i,    // presence pin, async
	input  wire logic               attn_button_i, // button pin, async
	output logic                    msg_valid_o,   // indicator message valid
	input  wire logic               msg_ready_i,   // link takes message
	output logic                    msg_kind_o,    // power or attention
	output logic      [1:0]         msg_code_o,    // on, blink or off
	output logic                    hp_irq_o,      // hot-plug interrupt level
	output logic                    wake_o         // wake message request pulse
);

	////////////////////////////////////////////////////////////////////
	// decode helpers

	// true when an access hits a register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////
	// declarations

	logic [`PSHP_SYNC_STAGES-1:0] pd_sync;     // presence synchroniser
	logic [`PSHP_SYNC_STAGES-1:0] btn_sync;    // button synchroniser
	logic                         btn_last_reg; // button previous level
	logic                         armed_reg;    // strap already taken
	logic                         pd_state_reg; // presence detect state
	pshp_pkg::pshp_ind_t          pwr_reg;      // power indicator
	pshp_pkg::pshp_ind_t          attn_reg;     // attention indicator
	logic                         hpie_reg;     // master interrupt enable
	logic                         ccie_reg;     // command done enable
	logic                         pdce_reg;     // presence change enable
	logic                         abpe_reg;     // button press enable
	logic                         cc_reg;       // command completed
	logic                         pdc_reg;      // presence changed
	logic                         abp_reg;      // button pressed
	logic                         pwr_pend_reg; // power message owed
	logic                         attn_pend_reg; // attention message owed
	pshp_pkg::pshp_msg_state_e    msg_state_reg; // message sender state
	logic                         wr_ctl;       // write to slot control
	logic                         wr_sts;       // write to slot status
	logic                         wr_pwr;       // power field written
	logic                         wr_attn;      // attention field written
	logic                         pd_change;    // presence edge seen
	logic                         btn_press;    // button rising edge
	logic                         msg_done;     // message accepted
	logic                         cc_event;     // command completion
	pshp_pkg::pshp_word_t         ctl_word;     // slot control view
	pshp_pkg::pshp_word_t         sts_word;     // slot status view

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// two flops per pin plus the button level one edge back;
	// only the last stage of each chain is read by logic
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pd_sync      <= {`PSHP_SYNC_STAGES{1'b0}};
			btn_sync     <= {`PSHP_SYNC_STAGES{1'b0}};
			btn_last_reg <= 1'b0;
		end else begin
			pd_sync      <= {pd_sync[`PSHP_SYNC_STAGES-2:0], presence_i};
			btn_sync     <= {btn_sync[`PSHP_SYNC_STAGES-2:0], attn_button_i};
			btn_last_reg <= btn_sync[`PSHP_SYNC_STAGES-1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// access decode and events

	// write strobes per register and per field lane
	assign wr_ctl  = cfg_wr_i && hit(cfg_addr_i, `PSHP_SLOT_CONTROL_OFF);
	assign wr_sts  = cfg_wr_i && hit(cfg_addr_i, `PSHP_SLOT_STATUS_OFF);
	// a reserved code is ignored and sends nothing
	assign wr_pwr  = wr_ctl && cfg_be_i[1] &&
		(cfg_wdata_i[`PSHP_CTL_PWR_HI:`PSHP_CTL_PWR_LO] != `PSHP_IND_RSVD);
	assign wr_attn = wr_ctl && cfg_be_i[0] &&
		(cfg_wdata_i[`PSHP_CTL_ATTN_HI:`PSHP_CTL_ATTN_LO] != `PSHP_IND_RSVD);

	assign pd_change = armed_reg && (pd_sync[`PSHP_SYNC_STAGES-1] != pd_state_reg);
	assign btn_press = btn_sync[`PSHP_SYNC_STAGES-1] && !btn_last_reg;
	// message handshake completes
	assign msg_done  = msg_valid_o && msg_ready_i;
	// command finishes on controller signal or last message sent
	assign cc_event  = cmd_done_i ||
		(msg_done && !pwr_pend_reg && !attn_pend_reg);

	////////////////////////////////////////////////////////////////////
	// presence state

	// strap taken at first edge after release, then pin tracked
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			armed_reg    <= 1'b0;
			pd_state_reg <= 1'b0;
		end else begin
			armed_reg    <= 1'b1;
			pd_state_reg <= pd_sync[`PSHP_SYNC_STAGES-1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// slot control register

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwr_reg <= `PSHP_IND_ON;
		end else if (wr_pwr) begin
			pwr_reg <= cfg_wdata_i[`PSHP_CTL_PWR_HI:`PSHP_CTL_PWR_LO];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			attn_reg <= `PSHP_IND_OFF;
		end else if (wr_attn) begin
			attn_reg <= cfg_wdata_i[`PSHP_CTL_ATTN_HI:`PSHP_CTL_ATTN_LO];
		end
	end

	// enable bits all live in the low byte
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hpie_reg <= 1'b0;
			ccie_reg <= 1'b0;
			pdce_reg <= 1'b0;
			abpe_reg <= 1'b0;
		end else if (wr_ctl && cfg_be_i[0]) begin
			hpie_reg <= cfg_wdata_i[`PSHP_CTL_HPIE];
			ccie_reg <= cfg_wdata_i[`PSHP_CTL_CCIE];
			pdce_reg <= cfg_wdata_i[`PSHP_CTL_PDCE];
			abpe_reg <= cfg_wdata_i[`PSHP_CTL_ABPE];
		end
	end

	////////////////////////////////////////////////////////////////////
	// slot status register

	// write one clears, a new event in the same cycle wins
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cc_reg  <= 1'b0;
			pdc_reg <= 1'b0;
			abp_reg <= 1'b0;
		end else begin
			cc_reg  <= cc_event || (cc_reg &&
				!(wr_sts && cfg_be_i[0] && cfg_wdata_i[`PSHP_STS_CC]));
			pdc_reg <= pd_change || (pdc_reg &&
				!(wr_sts && cfg_be_i[0] && cfg_wdata_i[`PSHP_STS_PDC]));
			abp_reg <= btn_press || (abp_reg &&
				!(wr_sts && cfg_be_i[0] && cfg_wdata_i[`PSHP_STS_ABP]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path

	// register views, reserved bits zero
	always_comb begin
		ctl_word = 16'h0000;
		ctl_word[`PSHP_CTL_PWR_HI:`PSHP_CTL_PWR_LO]   = pwr_reg;
		ctl_word[`PSHP_CTL_ATTN_HI:`PSHP_CTL_ATTN_LO] = attn_reg;
		ctl_word[`PSHP_CTL_HPIE] = hpie_reg;
		ctl_word[`PSHP_CTL_CCIE] = ccie_reg;
		ctl_word[`PSHP_CTL_PDCE] = pdce_reg;
		ctl_word[`PSHP_CTL_ABPE] = abpe_reg;
		sts_word = 16'h0000;
		sts_word[`PSHP_STS_PDS] = pd_state_reg;
		sts_word[`PSHP_STS_CC]  = cc_reg;
		sts_word[`PSHP_STS_PDC] = pdc_reg;
		sts_word[`PSHP_STS_ABP] = abp_reg;
	end

	// read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_rdata_o  <= 16'h0000;
			cfg_rvalid_o <= 1'b0;
		end else begin
			cfg_rvalid_o <= cfg_rd_i;
			if (cfg_rd_i && hit(cfg_addr_i, `PSHP_SLOT_CONTROL_OFF)) begin
				cfg_rdata_o <= ctl_word;
			end else if (cfg_rd_i && hit(cfg_addr_i, `PSHP_SLOT_STATUS_OFF)) begin
				cfg_rdata_o <= sts_word;
			end else begin
				cfg_rdata_o <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// indicator messages

	// owed messages; a new write wins over the clear on load
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwr_pend_reg  <= 1'b0;
			attn_pend_reg <= 1'b0;
		end else begin
			pwr_pend_reg  <= wr_pwr || (pwr_pend_reg &&
				!(msg_state_reg == pshp_pkg::PSHP_MSG_IDLE));
			attn_pend_reg <= wr_attn || (attn_pend_reg &&
				!(msg_state_reg == pshp_pkg::PSHP_MSG_IDLE && !pwr_pend_reg));
		end
	end

	// sender: power first, holds valid until the link takes it
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			msg_state_reg <= pshp_pkg::PSHP_MSG_IDLE;
			msg_valid_o   <= 1'b0;
			msg_kind_o    <= `PSHP_MSG_POWER;
			msg_code_o    <= `PSHP_IND_OFF;
		end else begin
			unique case (msg_state_reg)
				pshp_pkg::PSHP_MSG_IDLE: begin
					if (pwr_pend_reg) begin
						msg_state_reg <= pshp_pkg::PSHP_MSG_BUSY;
						msg_valid_o   <= 1'b1;
						msg_kind_o    <= `PSHP_MSG_POWER;
						msg_code_o    <= pwr_reg;
					end else if (attn_pend_reg) begin
						msg_state_reg <= pshp_pkg::PSHP_MSG_BUSY;
						msg_valid_o   <= 1'b1;
						msg_kind_o    <= `PSHP_MSG_ATTN;
						msg_code_o    <= attn_reg;
					end
				end
				pshp_pkg::PSHP_MSG_BUSY: begin
					if (msg_ready_i) begin
						msg_state_reg <= pshp_pkg::PSHP_MSG_IDLE;
						msg_valid_o   <= 1'b0;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt and wake

	// level interrupt behind master enable
	// wake pulses for enabled presence or button events while interrupts are off
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hp_irq_o <= 1'b0;
			wake_o   <= 1'b0;
		end else begin
			hp_irq_o <= hpie_reg && ((cc_reg && ccie_reg) ||
				(pdc_reg && pdce_reg) || (abp_reg && abpe_reg));
			wake_o   <= !hpie_reg && ((pd_change && pdce_reg) ||
				(btn_press && abpe_reg));
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_pwr_write;
		wr_pwr && msg_state_reg == pshp_pkg::PSHP_MSG_IDLE && !attn_pend_reg;
	endsequence
	sequence s_pwr_sent;
		msg_valid_o && msg_kind_o == `PSHP_MSG_POWER;
	endsequence
	a_pwr_read_back: assert property (
		cfg_rd_i && hit(cfg_addr_i, `PSHP_SLOT_CONTROL_OFF) |=>
		cfg_rvalid_o && cfg_rdata_o[9:8] == $past(pwr_reg))
		else $error("power indicator read mismatch");
	a_pwr_msg_sent: assert property (
		s_pwr_write |-> ##[1:2] s_pwr_sent)
		else $error("power message not sent");
	a_attn_read_back: assert property (
		cfg_rd_i && hit(cfg_addr_i, `PSHP_SLOT_CONTROL_OFF) |=>
		cfg_rdata_o[7:6] == $past(attn_reg))
		else $error("attention indicator read mismatch");
	a_attn_msg_owed: assert property (
		wr_attn |=> attn_pend_reg && attn_reg == $past(cfg_wdata_i[7:6]))
		else $error("attention write not taken");
	a_irq_master_gate: assert property (
		!hpie_reg |=> !hp_irq_o)
		else $error("interrupt without master enable");
	a_cc_irq_raise: assert property (
		hpie_reg && ccie_reg && cc_event ##1 hpie_reg && ccie_reg |=> hp_irq_o)
		else $error("command completion interrupt missing");
	a_pdc_irq_wake: assert property (
		pd_change && pdce_reg && !hpie_reg |=> wake_o)
		else $error("presence change wake missing");
	a_abp_irq_wake: assert property (
		btn_press && abpe_reg && !hpie_reg |=> wake_o && abp_reg)
		else $error("button press wake missing");
	a_pd_state_track: assert property (
		armed_reg |=> pd_state_reg == $past(pd_sync[`PSHP_SYNC_STAGES-1]))
		else $error("presence state not tracking pin");
	a_cc_set_event: assert property (
		cmd_done_i |=> cc_reg)
		else $error("command completed not set");
	a_pdc_set_edge: assert property (
		pd_change |=> pdc_reg)
		else $error("presence changed not set");
	a_abp_set_press: assert property (
		$rose(btn_sync[`PSHP_SYNC_STAGES-1]) |=> abp_reg)
		else $error("button pressed not set");
	a_w1c_clear: assert property (
		wr_sts && cfg_be_i[0] && cfg_wdata_i[0] && !btn_press |=> !abp_reg)
		else $error("write one did not clear");
	a_irq_combine: assert property (
		hpie_reg && pdce_reg && pdc_reg |=> hp_irq_o)
		else $error("interrupt missing for enabled status");

endmodule

// >>> tb/pshp_slot_model.sv
// downstream slot model: takes indicator messages, drives its lamps
// assumes the port holds each message until it sees ready high
`timescale 1ns/100ps

module pshp_slot_model (
	input  wire logic       clk_i,       // port clock
	input  wire logic       sys_rst_i,   // async reset, active high
	input  wire logic       slow_i,      // stall the link before each take
	input  wire logic       msg_valid_i, // message offered by the port
	input  wire logic       msg_kind_i,  // power or attention
	input  wire logic [1:0] msg_code_i,  // on, blink or off
	output logic            msg_ready_o, // message taken this cycle
	output logic      [1:0] pwr_lamp_o,  // power lamp state
	output logic      [1:0] attn_lamp_o, // attention lamp state
	output logic      [7:0] msg_cnt_o    // messages taken so far
);
	logic [1:0] wait_reg; // stalled cycles of the waiting message

	////////////////////////////////////////////////////////////////////////////////
	// stall count: a slow link takes a message only after three cycles
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_reg <= 2'h0;
		end else if (msg_valid_i && !msg_ready_o) begin
			wait_reg <= wait_reg + 2'h1;
		end else begin
			wait_reg <= 2'h0;
		end
	end

	assign msg_ready_o = msg_valid_i && (!slow_i || wait_reg == 2'h3);

	////////////////////////////////////////////////////////////////////////////////
	// lamps follow each taken message; reset state matches the port's
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pwr_lamp_o <= 2'h1;
			attn_lamp_o <= 2'h3;
			msg_cnt_o <= 8'h00;
		end else if (msg_ready_o) begin
			msg_cnt_o <= msg_cnt_o + 8'h01;
			if (msg_kind_i) begin
				attn_lamp_o <= msg_code_i;
			end else begin
				pwr_lamp_o <= msg_code_i;
			end
		end
	end
endmodule

// >>> tb/tb_pcie_slot_hotplug_ctl_status.sv
// testbench of the slot hot-plug control and status registers
// assumes the slot model beside it and the constants header on the path
`timescale 1ns/100ps
`include "pshp_params.svh"

module tb_pcie_slot_hotplug_ctl_status;
	logic        clk_i, sys_rst_i, cfg_wr_i, cfg_rd_i, cmd_done_i;
	logic        presence_i, attn_button_i, slow, cfg_rvalid_o, msg_valid_o;
	logic        msg_ready, msg_kind_o, hp_irq_o, wake_o;
	logic [7:0]  cfg_addr_i, msg_cnt;
	logic [1:0]  cfg_be_i, msg_code_o, pwr_lamp, attn_lamp;
	logic [15:0] cfg_wdata_i, cfg_rdata_o, m_ctl, m_sts, r;
	int          fails, num_checks, cycles, wakes, exp_wakes, seed;

	pshp_slot_ctl pshp_slot_ctl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid_o), .cmd_done_i(cmd_done_i), .presence_i(presence_i),
		.attn_button_i(attn_button_i), .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready),
		.msg_kind_o(msg_kind_o), .msg_code_o(msg_code_o), .hp_irq_o(hp_irq_o),
		.wake_o(wake_o));
	pshp_slot_model pshp_slot_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.slow_i(slow), .msg_valid_i(msg_valid_o), .msg_kind_i(msg_kind_o),
		.msg_code_i(msg_code_o), .msg_ready_o(msg_ready), .pwr_lamp_o(pwr_lamp),
		.attn_lamp_o(attn_lamp), .msg_cnt_o(msg_cnt));

	////////////////////////////////////////////////////////////////////////////////
	// clock, wake pulse count and hang guard
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (wake_o === 1'b1) wakes++;
		cycles++;
		if (cycles == 6000) begin
			fails++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, bus cycles and the reference model
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk_i);
		cfg_wr_i <= 1'b1;
		cfg_addr_i <= a;
		cfg_be_i <= be;
		cfg_wdata_i <= d;
		@(posedge clk_i);
		cfg_wr_i <= 1'b0;
	endtask
	// read answers one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		cfg_rd_i <= 1'b1;
		cfg_addr_i <= a;
		@(posedge clk_i);
		cfg_rd_i <= 1'b0;
		#1;
		chk({15'h0, cfg_rvalid_o}, 16'h0001);
		chk(cfg_rdata_o, exp);
	endtask
	// model interrupt level: status, its enable and the master enable
	function automatic logic irq_exp();
		return m_ctl[5] && ((m_sts[4] && m_ctl[4]) || (m_sts[3] && m_ctl[3])
			|| (m_sts[0] && m_ctl[0]));
	endfunction
	// control write: a nonzero indicator code updates and sends a message
	task automatic ctl_wr(input logic [1:0] be, input logic [15:0] d);
		logic [7:0] n;
		n = msg_cnt;
		if (be[1] && d[9:8] != 2'h0) begin
			m_ctl[9:8] = d[9:8];
			n++;
		end
		if (be[0]) begin
			m_ctl[5:0] = d[5:0] & 6'h39;
			if (d[7:6] != 2'h0) begin
				m_ctl[7:6] = d[7:6];
				n++;
			end
		end
		if (n != msg_cnt) m_sts[4] = 1'b1;
		wr(`PSHP_SLOT_CONTROL_OFF, be, d);
		for (int k = 0; k < 40 && msg_cnt != n; k++) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
		chk({8'h0, msg_cnt}, {8'h0, n});
		chk({14'h0, pwr_lamp}, {14'h0, m_ctl[9:8]});
		chk({14'h0, attn_lamp}, {14'h0, m_ctl[7:6]});
		rd(`PSHP_SLOT_CONTROL_OFF, m_ctl);
	endtask
	// status write of ones clears those event bits only
	task automatic sts_clr(input logic [15:0] d);
		m_sts = m_sts & ~(d & 16'h0019);
		wr(`PSHP_SLOT_STATUS_OFF, 2'b11, d);
		repeat (2) @(posedge clk_i);
		rd(`PSHP_SLOT_STATUS_OFF, m_sts);
	endtask
	// one hot-plug event: 0 command done, 1 presence edge, 2 button press
	task automatic event_go(input int kind);
		@(posedge clk_i);
		if (kind == 0) begin
			cmd_done_i <= 1'b1;
			@(posedge clk_i);
			cmd_done_i <= 1'b0;
			m_sts[4] = 1'b1;
		end else if (kind == 1) begin
			presence_i <= !presence_i;
			m_sts[6] = !m_sts[6];
			m_sts[3] = 1'b1;
			if (m_ctl[3] && !m_ctl[5]) exp_wakes++;
		end else begin
			attn_button_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			attn_button_i <= 1'b0;
			m_sts[0] = 1'b1;
			if (m_ctl[0] && !m_ctl[5]) exp_wakes++;
		end
		repeat (8) @(posedge clk_i);
		rd(`PSHP_SLOT_STATUS_OFF, m_sts);
		chk({15'h0, hp_irq_o}, {15'h0, irq_exp()});
		chk(wakes[15:0], exp_wakes[15:0]);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'ha5a7;
		{cfg_wr_i, cfg_rd_i, cmd_done_i, presence_i, attn_button_i, slow} = 6'h00;
		cfg_addr_i = 8'h00;
		cfg_be_i = 2'h0;
		cfg_wdata_i = 16'h0000;
		sys_rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		m_ctl = `PSHP_SLOT_CONTROL_RST;
		m_sts = `PSHP_SLOT_STATUS_RST;
		repeat (4) @(posedge clk_i);
		rd(`PSHP_SLOT_CONTROL_OFF, m_ctl);
		rd(`PSHP_SLOT_STATUS_OFF, m_sts);
		// unmapped place reads zero and ignores writes
		wr(8'hbc, 2'b11, 16'hffff);
		rd(8'hbc, 16'h0000);
		rd(`PSHP_SLOT_CONTROL_OFF, m_ctl);
		$display("test reset and map done");
		// every indicator code on both fields, link fast then stalling
		for (int i = 0; i < 8; i++) begin
			slow = i[2];
			r[1:0] = i[1:0] + 2'h1;
			ctl_wr(2'b11, {6'h00, i[1:0], r[1:0], 6'h00});
		end
		// power lane alone: the low byte must be left untouched
		ctl_wr(2'b10, 16'h02ff);
		sts_clr(16'h0019);
		$display("test indicators done");
		// random enables, one event each, then a random clearing write
		for (int i = 0; i < 30; i++) begin
			r = 16'($random(seed));
			ctl_wr(2'b01, {8'h00, 2'h3, r[5:0]});
			sts_clr(16'h0019);
			chk({15'h0, hp_irq_o}, 16'h0000);
			event_go(i % 3);
			sts_clr(r ^ 16'h5a5a);
			chk({15'h0, hp_irq_o}, {15'h0, irq_exp()});
		end
		$display("test events done");
		tally_and_finish();
	end
endmodule
